/* File: core/timer_counter_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts
 * of the gated sixteen-bit timer/counter.
 * Assumes inclusion by bare name from design files of this block.
 */
// Summary of operation
// - The sixteen-bit count is two bytes, and a write to either byte replaces it at once.
// - Internal sources step once per instruction cycle, external ones once per selected edge.
// - The count is off with run-enable low, free with gate-enable low, and gated otherwise.
// - Source 00 is Fosc/4, 01 is Fosc, 10 is pin or crystal by oscillator-enable, 11 reserved.
// - With Fosc as source the count rises by four per instruction cycle.
// - External sources count rising edges, always through the synchroniser.
// - A hidden prescaler divides the input by 1, 2, 4 or 8 as a two-bit field selects.
// - Any write to a count byte clears the prescaler.
// - Counter mode needs a falling edge before counting a rise after enable, write or stop.
// - Oscillator-enable starts the 32.768 kHz crystal oscillator, which keeps running in sleep.
// - Sync-disable is stored but unused; the external input is synchronised in either setting.
// - External counting always runs through the aclk synchroniser; its overflow sets the sticky flag and there is no wake output.
// - Switching sync mode neither loses nor adds an increment.
// - The count rolls from FFFFh to 0000h and each rollover sets a sticky overflow flag.
// - Byte reads during external counting return a stable value.
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH

`define TC_ADDR_W           4
`define TC_OFF_COUNT_LOW    4'h0
`define TC_OFF_COUNT_HIGH   4'h4
`define TC_OFF_CONTROL      4'h8
`define TC_OFF_GATE_STATUS  4'hc

// Control register fields
`define TC_CTRL_RUN         0
`define TC_CTRL_SYNC_DIS    2
`define TC_CTRL_OSC_EN      3
`define TC_CTRL_PS_LO       4
`define TC_CTRL_PS_HI       5
`define TC_CTRL_CS_LO       6
`define TC_CTRL_CS_HI       7
`define TC_CTRL_RESET       8'h00
`define TC_CTRL_MASK        8'hfd

// Gate/status register fields
`define TC_GS_GATE_EN       0
`define TC_GS_GATE_POL      1
`define TC_GS_OVF           2
`define TC_GS_GATE_RESET    2'h0

`define TC_INSTR_DIV        4
`define TC_FOSC_STEP        16'h0004
`define TC_ONE_STEP         16'h0001

`endif

/* File: core/timer_counter_pkg.sv */
/*
 * Types of the gated sixteen-bit timer/counter.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package timer_counter_pkg;
  typedef enum logic [1:0] {
    src_instr,
    src_fosc,
    src_external,
    src_reserved
  } clock_source_t;
endpackage
`default_nettype wire

/* File: core/edge_sync.sv */
/*
 * Three-stage input synchroniser with agreement-based edge detect.
 * Assumes a single clock aclk and synchronous active-low reset.
 */
`default_nettype none
module edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stages;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stages <= 3'h0;
    end else begin
      stages <= {stages[1:0], async_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= 1'b0;
    end else if (stages[1] == stages[2]) begin
      level <= stages[2];
    end
  end

  assign rise = (stages[1] == stages[2]) && stages[2] && !level;
  assign fall = (stages[1] == stages[2]) && !stages[2] && level;
endmodule
`default_nettype wire

/* File: core/timer_counter.sv */
/*
 * Gated sixteen-bit timer/counter with AXI4-Lite register slave.
 * Assumes a 50 MHz aclk, synchronous active-low aresetn, and pins
 * (external count input, crystal input, gate) asynchronous to aclk.
 */
`default_nettype none
`include "timer_counter_regs.svh"
module timer_counter #(
  parameter int COUNT_W = 16,
  parameter int PS_W    = 3
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        external_count_input,
  input  wire logic        crystal_input_pin,
  output logic             crystal_output_pin,
  output logic             crystal_osc_running,
  input  wire logic        gate_input_pin,
  output logic             overflow_flag
);

  // ********************************************************
  // Control state
  // ********************************************************
  logic [7:0]         counter_control_reg;
  logic               gate_enable;
  logic               gate_polarity;
  logic [COUNT_W-1:0] count;
  logic [PS_W-1:0]    prescale;
  logic [1:0]         instr_phase;
  logic               armed;
  logic               run_enable;
  logic               sync_disable;
  logic               crystal_osc_enable;
  logic [1:0]         prescale_select;
  timer_counter_pkg::clock_source_t clock_source_select;

  assign run_enable          = counter_control_reg[`TC_CTRL_RUN];
  assign sync_disable        = counter_control_reg[`TC_CTRL_SYNC_DIS];
  assign crystal_osc_enable  = counter_control_reg[`TC_CTRL_OSC_EN];
  assign prescale_select     = counter_control_reg[`TC_CTRL_PS_HI:`TC_CTRL_PS_LO];
  assign clock_source_select =
    timer_counter_pkg::clock_source_t'(counter_control_reg[`TC_CTRL_CS_HI:`TC_CTRL_CS_LO]);

  // ********************************************************
  // Bus slave handshakes
  // ********************************************************
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_fire;
  logic       wr_low;
  logic       wr_high;
  logic       wr_ctrl;
  logic       wr_gs;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_low  = wr_fire && w_strb[0] && aw_addr == `TC_OFF_COUNT_LOW;
  assign wr_high = wr_fire && w_strb[0] && aw_addr == `TC_OFF_COUNT_HIGH;
  assign wr_ctrl = wr_fire && w_strb[0] && aw_addr == `TC_OFF_CONTROL;
  assign wr_gs   = wr_fire && w_strb[0] && aw_addr == `TC_OFF_GATE_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[3:2], 2'h0};
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_control_reg <= `TC_CTRL_RESET;
    end else if (wr_ctrl) begin
      counter_control_reg <= w_data[7:0] & `TC_CTRL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_enable   <= 1'b0;
      gate_polarity <= 1'b0;
    end else if (wr_gs) begin
      gate_enable   <= w_data[`TC_GS_GATE_EN];
      gate_polarity <= w_data[`TC_GS_GATE_POL];
    end
  end

  // ********************************************************
  // Input synchronisers
  // ********************************************************
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic xtal_level;
  logic xtal_rise;
  logic xtal_fall;
  logic gate_level;

  edge_sync ext_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (external_count_input),
    .level    (ext_level),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );

  edge_sync xtal_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (crystal_input_pin),
    .level    (xtal_level),
    .rise     (xtal_rise),
    .fall     (xtal_fall)
  );

  edge_sync gate_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (gate_input_pin),
    .level    (gate_level),
    .rise     (),
    .fall     ()
  );

  // ********************************************************
  // Crystal driver
  // ********************************************************
  // Inverting amplifier stage while enabled; runs regardless of sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crystal_output_pin  <= 1'b0;
      crystal_osc_running <= 1'b0;
    end else begin
      crystal_output_pin  <= crystal_osc_enable && !xtal_level;
      crystal_osc_running <= crystal_osc_enable;
    end
  end

  // ********************************************************
  // Source selection
  // ********************************************************
  logic instr_tick;
  logic src_rise;
  logic src_fall;
  logic external_mode;
  logic gate_open;
  logic counting;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  assign instr_tick    = instr_phase == 2'(`TC_INSTR_DIV - 1);
  assign external_mode = clock_source_select == timer_counter_pkg::src_external;
  // Pin or crystal chosen by oscillator enable
  assign src_rise = crystal_osc_enable ? xtal_rise : ext_rise;
  assign src_fall = crystal_osc_enable ? xtal_fall : ext_fall;
  // Gate level compared against polarity
  assign gate_open = !gate_enable || (gate_level == gate_polarity);
  assign counting  = run_enable && gate_open;

  // Both sync settings land on the same synchronised edge here, so a
  // mode switch neither loses nor gains a count
  logic src_pulse;
  logic [COUNT_W-1:0] step;

  always_comb begin
    src_pulse = 1'b0;
    step      = `TC_ONE_STEP;
    case (clock_source_select)
      timer_counter_pkg::src_instr: begin
        src_pulse = instr_tick;
      end
      timer_counter_pkg::src_fosc: begin
        src_pulse = instr_tick;
        step      = `TC_FOSC_STEP;
      end
      timer_counter_pkg::src_external: begin
        src_pulse = src_rise && armed;
      end
      default: begin
        src_pulse = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // Falling-edge arming for counter mode
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed <= 1'b0;
    end else if (!run_enable || wr_low || wr_high) begin
      armed <= 1'b0;
    end else if (src_fall) begin
      armed <= 1'b1;
    end
  end

  // ********************************************************
  // Prescaler and counter
  // ********************************************************
  logic ps_tick;
  logic [PS_W-1:0] ps_limit;
  assign ps_limit = PS_W'((1 << prescale_select) - 1);
  assign ps_tick  = counting && src_pulse && (prescale >= ps_limit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= '0;
    end else if (wr_low || wr_high) begin
      prescale <= '0;
    end else if (counting && src_pulse) begin
      prescale <= ps_tick ? '0 : prescale + PS_W'(1);
    end
  end

  logic [COUNT_W:0] sum;
  logic             rollover;
  logic [COUNT_W-1:0] fosc_step;
  // Fosc source: four counts per prescaled instruction cycle,
  // so the prescaler slows the rate rather than skipping phases
  assign fosc_step = step;
  logic fosc_tick;
  assign fosc_tick = ps_tick;
  assign sum      = {1'b0, count} + {1'b0, fosc_step};
  assign rollover = fosc_tick && sum[COUNT_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (wr_low) begin
      count[7:0] <= w_data[7:0];
    end else if (wr_high) begin
      count[15:8] <= w_data[7:0];
    end else if (fosc_tick) begin
      count <= sum[COUNT_W-1:0];
    end
  end

  // Sticky overflow; set wins over clear, also counts while asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (rollover) begin
      overflow_flag <= 1'b1;
    end else if (wr_gs && !w_data[`TC_GS_OVF]) begin
      overflow_flag <= 1'b0;
    end
  end

  // ********************************************************
  // Read channel
  // ********************************************************
  logic [31:0] next_rdata;

  assign s_axi_arready = !s_axi_rvalid;

  // Count is held in aclk flops, so byte reads never tear
  always_comb begin
    next_rdata = 32'h0;
    case ({s_axi_araddr[3:2], 2'h0})
      `TC_OFF_COUNT_LOW:   next_rdata = {24'h0, count[7:0]};
      `TC_OFF_COUNT_HIGH:  next_rdata = {24'h0, count[15:8]};
      `TC_OFF_CONTROL:     next_rdata = {24'h0, counter_control_reg};
      `TC_OFF_GATE_STATUS: next_rdata = {29'h0, overflow_flag, gate_polarity, gate_enable};
      default:             next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: sim/timer_counter_sva.sv */
/* Checker of bus answers and the overflow flag.
   Assumes a bind into timer_counter, one clock aclk. */
`default_nettype none
module timer_counter_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        overflow_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****
  // Handshake steps
  // ****
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bvalid_held: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("bvalid dropped early");
  a_rvalid_held: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("rvalid dropped early");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("bad bresp");
  a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("bad rresp");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_flag_sticky: assert property ($fell(overflow_flag) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
    else $error("flag cleared without write");
endmodule
bind timer_counter timer_counter_sva timer_counter_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .overflow_flag(overflow_flag));
`default_nettype wire

/* File: sim/timer_source_model.sv */
/* Far-side model: external count pin and crystal input.
   Assumes callers invoke pulses after a clock edge. */
`default_nettype none
module timer_source_model (
  input  wire logic aclk,
  output logic      external_count_input,
  output logic      crystal_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6;
  initial begin
    external_count_input = 1'b0;
    crystal_input_pin = 1'b0;
  end
  // Whole periods from low, line rests low between bursts
  task automatic pulses(input logic xtal, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      repeat (HALF) @(posedge aclk);
      if (xtal) crystal_input_pin <= ~crystal_input_pin;
      else external_count_input <= ~external_count_input;
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/gated_sixteen_bit_timer_counter_tb_top.sv */
/* Self-checking bench of timer_counter.
   Assumes the register header and source model are compiled. */
`default_nettype none
`include "timer_counter_regs.svh"
module gated_sixteen_bit_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] ctrl; logic [7:0] gs; logic gate; int cyc; int lo; int hi;} row_t;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, ext, xtal, osc_run, gate, ovf, xdrv;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [7:0]  d;
  logic [15:0] c;
  int          fail_count, total_checks, cycles;
  row_t        rows[9] = '{
    '{8'h01, 8'h0, 1'b0, 400, 96, 106}, '{8'h11, 8'h0, 1'b0, 400, 47, 54},
    '{8'h21, 8'h0, 1'b0, 400, 23, 27}, '{8'h31, 8'h0, 1'b0, 400, 11, 14},
    '{8'h41, 8'h0, 1'b0, 400, 388, 420}, '{8'h00, 8'h0, 1'b0, 400, 0, 0},
    '{8'h01, 8'h1, 1'b1, 400, 0, 0}, '{8'h01, 8'h3, 1'b1, 400, 94, 106},
    '{8'h51, 8'h0, 1'b0, 400, 188, 212}};
  timer_counter timer_counter_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_count_input(ext), .crystal_input_pin(xtal), .crystal_output_pin(xdrv),
    .crystal_osc_running(osc_run), .gate_input_pin(gate), .overflow_flag(ovf));
  timer_source_model src (.aclk(aclk), .external_count_input(ext), .crystal_input_pin(xtal));
  always #10 aclk = ~aclk;
  // ****
  // Bus and compare tasks
  // ****
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata[7:0];
    rready <= 1'b0;
  endtask
  task automatic set_count(input logic [15:0] v);
    axi_wr(`TC_OFF_COUNT_LOW, v[7:0]);
    axi_wr(`TC_OFF_COUNT_HIGH, v[15:8]);
  endtask
  task automatic get_count(output logic [15:0] v);
    axi_rd(`TC_OFF_COUNT_LOW, v[7:0]);
    axi_rd(`TC_OFF_COUNT_HIGH, v[15:8]);
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input logic [15:0] g);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      final_report();
    end
  end
  // ****
  // Sequence
  // ****
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    gate = 1'b0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`TC_OFF_CONTROL, d);
    chk("control reset", {8'h0, `TC_CTRL_RESET}, {8'h0, d});
    set_count(16'h3ca5);
    get_count(c);
    chk("count write", 16'h3ca5, c);
    $display("register test done");
    foreach (rows[i]) begin
      set_count(16'h0000);
      gate <= rows[i].gate;
      axi_wr(`TC_OFF_GATE_STATUS, rows[i].gs);
      axi_wr(`TC_OFF_CONTROL, rows[i].ctrl);
      repeat (rows[i].cyc) @(posedge aclk);
      axi_wr(`TC_OFF_CONTROL, rows[i].ctrl & 8'hfe);
      get_count(c);
      chk_rng("count", rows[i].lo, rows[i].hi, c);
      if (rows[i].ctrl[7:6] == 2'b01) chk("fosc step", 16'h0, {14'h0, c[1:0]});
      $display("row %0d done", i);
    end
    axi_wr(`TC_OFF_GATE_STATUS, 8'h00);
    set_count(16'hfffe);
    axi_wr(`TC_OFF_CONTROL, 8'h01);
    repeat (20) @(posedge aclk);
    axi_wr(`TC_OFF_CONTROL, 8'h00);
    get_count(c);
    chk_rng("count after wrap", 2, 8, c);
    axi_rd(`TC_OFF_GATE_STATUS, d);
    chk("status flag", 16'h4, {8'h0, d & 8'h04});
    axi_wr(`TC_OFF_GATE_STATUS, 8'h00);
    @(posedge aclk);
    chk("flag cleared", 16'h0, {15'h0, ovf});
    $display("rollover done");
    for (int s = 0; s < 2; s++) begin
      set_count(16'h0000);
      axi_wr(`TC_OFF_CONTROL, 8'h81 | 8'(s << 2));
      src.pulses(1'b0, 5);
      repeat (8) @(posedge aclk);
      axi_wr(`TC_OFF_CONTROL, 8'h00);
      get_count(c);
      chk("pin count", 16'h0004, c);
      $display("pin mode %0d done", s);
    end
    set_count(16'hfc00);
    axi_wr(`TC_OFF_CONTROL, 8'h89);
    @(posedge aclk);
    chk("osc running", 16'h1, {15'h0, osc_run});
    src.pulses(1'b1, 1025);
    repeat (8) @(posedge aclk);
    chk("startup flag", 16'h1, {15'h0, ovf});
    chk("osc drive", 16'h1, {15'h0, xdrv});
    axi_wr(`TC_OFF_CONTROL, 8'h00);
    get_count(c);
    chk("startup count", 16'h0000, c);
    chk("osc stopped", 16'h0, {14'h0, osc_run, xdrv});
    $display("crystal done");
    axi_wr(`TC_OFF_CONTROL, 8'h01);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("flag after reset", 16'h0, {15'h0, ovf});
    axi_rd(`TC_OFF_CONTROL, d);
    chk("control after reset", 16'h0, {8'h0, d});
    get_count(c);
    chk("count after reset", 16'h0, c);
    $display("reset done");
    final_report();
  end
endmodule
`default_nettype wire
